// ==== hw/bfm_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - catch switch levels at reset
// - drive caught configuration during dsp reset
// - only one mode at a time
// - mode pin counts only after boot
// - mode pin low selects register access
// - registers reachable only in register mode
// - serve register cycles over gpio pins
// - mode pin high selects flash pass-through
// - pass-through wires gpio to flash pins
// - write-protect follows control register bit four
// - no flash path in register mode
// - two leds, two switches through registers
// - ready low stretches read and write
// - gpio 8-13 map to flash strobes
// - bridge interrupt passed to processor pin
module bfm_top
  import bfm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [CFG_W-1:0] i_cfg_sw,
  output logic [CFG_W-1:0] o_cfg_drv,
  output logic o_cfg_oe_n,
  output logic o_dsp_rst_n,
  input wire logic i_boot_done,
  input wire logic [7:0] i_gp_data,
  output logic [7:0] o_gp_data,
  output logic o_gp_data_oe_n,
  input wire logic [1:0] i_bus_command_pins,
  input wire logic i_gp_strobe,
  output logic o_cycle_ready_pin,
  input wire logic i_gp_re_n,
  input wire logic i_gp_ce_n,
  input wire logic i_mode_select,
  output logic o_bridge_irq_pin,
  input wire logic i_bridge_irq,
  input wire logic [7:0] i_flash_data,
  output logic [7:0] o_flash_data,
  output logic o_flash_data_oe_n,
  output logic o_flash_cle,
  output logic o_flash_ale,
  output logic o_flash_we_n,
  output logic o_flash_re_n,
  output logic o_flash_ce_n,
  output logic o_flash_wp_n,
  input wire logic i_flash_rb,
  output logic [1:0] o_user_led,
  input wire logic [1:0] i_user_sw
);
  logic pass_mode_r;
  logic strobe_q_r;
  logic wait_r;
  logic [7:0] addr_r;
  logic [7:0] rdata_r;
  logic [7:0] flash_ctl_r;
  logic [1:0] led_r;
  logic [7:0] rd_mux;

  bfm_cfg_latch u_cfg (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_cfg_sw(i_cfg_sw),
    .o_cfg_drv(o_cfg_drv),
    .o_cfg_oe_n(o_cfg_oe_n),
    .o_dsp_rst_n(o_dsp_rst_n)
  );

  // mode is taken one clock after the pin; before boot the pin is ignored
  wire boot_ok = o_dsp_rst_n & i_boot_done;
  wire pass_nxt = boot_ok & i_mode_select;

  // register bus decode, live only in register mode
  wire stb_rise = i_gp_strobe & ~strobe_q_r;
  wire reg_cyc = stb_rise & ~pass_mode_r;
  wire reg_addr = reg_cyc & (i_bus_command_pins == CMD_ADDR);
  wire reg_rd = reg_cyc & (i_bus_command_pins == CMD_READ);
  wire reg_wr = reg_cyc & (i_bus_command_pins == CMD_WRITE);
  wire wr_user = reg_wr & (addr_r == REG_USER);
  wire wr_fctl = reg_wr & (addr_r == REG_FLASH_CTL_H);
  wire drive_rd = ~pass_mode_r & i_gp_strobe & (i_bus_command_pins == CMD_READ);
  // flash owns the data bus only while both its enables are low
  wire flash_talks = ~i_gp_ce_n & ~i_gp_re_n;

  always_comb
  begin
    rd_mux = 8'h00;
    case (addr_r)
      REG_CFG_LO: rd_mux = o_cfg_drv[7:0];
      REG_CFG_HI: rd_mux = o_cfg_drv[15:8];
      REG_USER:
      begin
        rd_mux[LED_LSB +: 2] = led_r;
        rd_mux[SW_LSB +: 2] = i_user_sw;
      end
      REG_FLASH_CTL_H: rd_mux = flash_ctl_r;
      REG_STATUS:
      begin
        rd_mux[STAT_BOOT_BIT] = boot_ok;
        rd_mux[STAT_PASS_BIT] = pass_mode_r;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pass_mode_r <= 1'b0;
      strobe_q_r <= 1'b0;
      wait_r <= 1'b0;
    end
    else
    begin
      pass_mode_r <= pass_nxt;
      strobe_q_r <= i_gp_strobe;
      wait_r <= reg_rd | reg_wr;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      addr_r <= ADDR_RST;
      rdata_r <= RDATA_RST;
    end
    else
    begin
      if (reg_addr)
      begin
        addr_r <= i_gp_data;
      end
      if (reg_rd)
      begin
        rdata_r <= rd_mux;
      end
    end
  end

  // control bits hold across mode changes; only a register-mode write moves them
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      led_r <= LED_RST;
      flash_ctl_r <= FLASH_CTL_RST;
    end
    else
    begin
      if (wr_user)
      begin
        led_r <= i_gp_data[LED_LSB +: 2];
      end
      if (wr_fctl)
      begin
        flash_ctl_r <= i_gp_data;
      end
    end
  end

  // pin mux: pass-through is pure wiring so flash timing is the processor's own
  assign o_flash_cle = pass_mode_r & i_bus_command_pins[0];
  assign o_flash_ale = pass_mode_r & i_bus_command_pins[1];
  assign o_flash_we_n = ~pass_mode_r | i_gp_strobe;
  assign o_flash_re_n = ~pass_mode_r | i_gp_re_n;
  assign o_flash_ce_n = ~pass_mode_r | i_gp_ce_n;
  assign o_flash_data = i_gp_data;
  assign o_flash_data_oe_n = ~pass_mode_r | flash_talks;
  assign o_flash_wp_n = flash_ctl_r[WP_BIT];
  assign o_gp_data = pass_mode_r ? i_flash_data : rdata_r;
  assign o_gp_data_oe_n = pass_mode_r ? ~flash_talks : ~drive_rd;
  assign o_cycle_ready_pin = pass_mode_r ? i_flash_rb : ~wait_r;
  assign o_user_led = led_r;
  assign o_bridge_irq_pin = i_bridge_irq;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence s_rdwr_start;
    !pass_mode_r && stb_rise && i_bus_command_pins[1];
  endsequence
  sequence s_one_wait;
    !o_cycle_ready_pin ##1 o_cycle_ready_pin;
  endsequence
  sequence s_fctl_write;
    !pass_mode_r && stb_rise && (i_bus_command_pins == CMD_WRITE) && (addr_r == REG_FLASH_CTL_H);
  endsequence

  mode_excl_a: assert property (pass_mode_r |-> !reg_wr && !reg_rd && !reg_addr)
    else $error("register cycle taken in pass-through mode");
  boot_gate_a: assert property (!i_boot_done |=> !pass_mode_r)
    else $error("mode pin acted before boot completed");
  mode_low_a: assert property (boot_ok && !i_mode_select |=> !pass_mode_r)
    else $error("low mode pin did not give register mode");
  mode_high_a: assert property (boot_ok && i_mode_select |=> pass_mode_r)
    else $error("high mode pin did not give pass-through mode");
  reg_ignore_a: assert property (pass_mode_r && stb_rise |=> $stable(led_r) && $stable(flash_ctl_r))
    else $error("register changed during pass-through");
  user_rw_a: assert property (!pass_mode_r && stb_rise && (i_bus_command_pins == CMD_READ)
    && (addr_r == REG_USER) |=> o_gp_data[SW_LSB +: 2] == $past(i_user_sw))
    else $error("switch read returned wrong value");
  led_write_a: assert property (!pass_mode_r && stb_rise && (i_bus_command_pins == CMD_WRITE)
    && (addr_r == REG_USER) |=> o_user_led == $past(i_gp_data[LED_LSB +: 2]))
    else $error("led write not applied");
  wp_write_a: assert property (s_fctl_write |=> o_flash_wp_n == $past(i_gp_data[WP_BIT]))
    else $error("write-protect pin not set from control bit");
  wp_hold_a: assert property ((pass_mode_r != $past(pass_mode_r)) && !$past(wr_fctl)
    |-> $stable(o_flash_wp_n))
    else $error("write-protect moved on a mode change");
  flash_idle_a: assert property (!pass_mode_r |-> o_flash_ce_n && o_flash_we_n && o_flash_data_oe_n)
    else $error("flash reached in register mode");
  pass_map_a: assert property (pass_mode_r |-> o_flash_cle == i_bus_command_pins[0]
    && o_flash_ale == i_bus_command_pins[1] && o_flash_we_n == i_gp_strobe && o_cycle_ready_pin == i_flash_rb)
    else $error("pass-through pin map broken");
  ready_wait_a: assert property (s_rdwr_start |=> s_one_wait)
    else $error("ready wait not one cycle");
  irq_follow_a: assert property ($rose(i_bridge_irq) |-> o_bridge_irq_pin)
    else $error("bridge interrupt not passed");

  // register-bus steps: address capture, cycles without waits, read data per offset
  sequence s_addr_start;
    !pass_mode_r && stb_rise && (i_bus_command_pins == CMD_ADDR);
  endsequence
  sequence s_plain_start;
    !pass_mode_r && stb_rise && !i_bus_command_pins[1];
  endsequence
  sequence s_fctl_read;
    !pass_mode_r && stb_rise && (i_bus_command_pins == CMD_READ) && (addr_r == REG_FLASH_CTL_H);
  endsequence
  sequence s_user_read;
    !pass_mode_r && stb_rise && (i_bus_command_pins == CMD_READ) && (addr_r == REG_USER);
  endsequence
  sequence s_cfg_lo;
    !pass_mode_r && stb_rise && (i_bus_command_pins == CMD_READ) && (addr_r == REG_CFG_LO);
  endsequence
  sequence s_cfg_hi;
    !pass_mode_r && stb_rise && (i_bus_command_pins == CMD_READ) && (addr_r == REG_CFG_HI);
  endsequence
  sequence s_stat_read;
    !pass_mode_r && stb_rise && (i_bus_command_pins == CMD_READ) && (addr_r == REG_STATUS);
  endsequence
  sequence s_pass_strobe;
    pass_mode_r && stb_rise;
  endsequence

  addr_take_a: assert property (s_addr_start |=> addr_r == $past(i_gp_data))
    else $error("address cycle did not load the address");

  no_wait_a: assert property (s_plain_start |=> o_cycle_ready_pin || pass_mode_r)
    else $error("ready pulled low outside read or write");

  fctl_read_a: assert property (s_fctl_read |=> o_gp_data == $past(flash_ctl_r))
    else $error("control register read returned wrong value");

  led_read_a: assert property (s_user_read |=> o_gp_data[LED_LSB +: 2] == $past(led_r))
    else $error("led read returned wrong value");

  cfg_low_a: assert property (s_cfg_lo |=> o_gp_data == $past(o_cfg_drv[7:0]))
    else $error("low configuration byte read wrong");

  cfg_high_a: assert property (s_cfg_hi |=> o_gp_data == $past(o_cfg_drv[15:8]))
    else $error("high configuration byte read wrong");

  stat_read_a: assert property (s_stat_read |=> !rdata_r[STAT_PASS_BIT]
    && (rdata_r[STAT_BOOT_BIT] == $past(boot_ok)))
    else $error("status read wrong");

  pass_quiet_a: assert property (s_pass_strobe |=> !wait_r && $stable(addr_r) && $stable(rdata_r))
    else $error("register bus reacted in pass-through mode");

  // pass-through wiring, both directions of the data bus
  pass_strb_a: assert property (pass_mode_r |-> o_flash_re_n == i_gp_re_n && o_flash_ce_n == i_gp_ce_n)
    else $error("read or chip enable not passed through");

  pass_read_a: assert property (pass_mode_r && flash_talks |-> !o_gp_data_oe_n && o_flash_data_oe_n
    && o_gp_data == i_flash_data)
    else $error("flash read data not passed to processor");

  pass_write_a: assert property (pass_mode_r && !flash_talks |-> o_gp_data_oe_n && !o_flash_data_oe_n
    && o_flash_data == i_gp_data)
    else $error("processor data not passed to flash");

  // register mode leaves the data pins to the processor unless a read is under way
  bus_quiet_a: assert property (!pass_mode_r && !i_gp_strobe |-> o_gp_data_oe_n)
    else $error("data pins driven with no read cycle");

  // control bits move only on their own register write
  wp_only_a: assert property (!$past(wr_fctl) |-> $stable(o_flash_wp_n))
    else $error("write-protect moved without a control write");

  led_only_a: assert property (!$past(wr_user) |-> $stable(o_user_led))
    else $error("leds moved without a user register write");

  // the mode pin has no say while the processor is still held in reset
  rst_gate_a: assert property (!o_dsp_rst_n |=> !pass_mode_r)
    else $error("pass-through entered during processor reset");

  irq_fall_a: assert property ($fell(i_bridge_irq) |-> !o_bridge_irq_pin)
    else $error("bridge interrupt release not passed");
endmodule : bfm_top

// ==== hw/bfm_pkg.sv ====
package bfm_pkg;
  // clock and time base
  localparam int CLK_PERIOD_PS = 5000;
  // dsp reset hold after the switches are caught, least time
  localparam int DSP_RST_NS = 1000;
  localparam int DSP_RST_CYC = (DSP_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CNT_W = 8;

  localparam int CFG_W = 16;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;

  // register-access bus commands on bus_command_pins
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_ADDR = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_WRITE = 2'h3;

  // register offsets on the 8-bit address
  localparam logic [7:0] REG_CFG_LO = 8'h00;
  localparam logic [7:0] REG_CFG_HI = 8'h01;
  localparam logic [7:0] REG_USER = 8'h10;
  localparam logic [7:0] REG_FLASH_CTL_H = 8'h21;
  localparam logic [7:0] REG_STATUS = 8'h22;

  // field positions
  localparam int LED_LSB = 0;
  localparam int SW_LSB = 4;
  localparam int WP_BIT = 4;
  localparam int STAT_BOOT_BIT = 0;
  localparam int STAT_PASS_BIT = 1;

  // values after reset
  localparam logic [7:0] FLASH_CTL_RST = 8'h00;
  localparam logic [1:0] LED_RST = 2'h0;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef enum logic [1:0] {BFM_CAPTURE, BFM_HOLD, BFM_RUN} bfm_boot_t;
endpackage : bfm_pkg

// ==== hw/bfm_cfg_latch.sv ====
`timescale 1ns/1ps
module bfm_cfg_latch
  import bfm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [CFG_W-1:0] i_cfg_sw,
  output logic [CFG_W-1:0] o_cfg_drv,
  output logic o_cfg_oe_n,
  output logic o_dsp_rst_n
);
  bfm_boot_t state_r;
  bfm_boot_t state_nxt;
  logic [RST_CNT_W-1:0] cnt_r;
  logic [RST_CNT_W-1:0] cnt_nxt;
  logic [CFG_W-1:0] cfg_r;
  wire hold_done = (cnt_r == RST_CNT_W'(DSP_RST_CYC - 1));

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      BFM_CAPTURE:
      begin
        state_nxt = BFM_HOLD;
        cnt_nxt = '0;
      end
      BFM_HOLD:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (hold_done)
        begin
          state_nxt = BFM_RUN;
        end
      end
      BFM_RUN:
      begin
        state_nxt = BFM_RUN;
      end
      default:
      begin
        state_nxt = BFM_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= BFM_CAPTURE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // switches are caught by the clock after release, never by the async reset
  always_ff @(posedge i_mclk)
  begin
    if (state_r == BFM_CAPTURE)
    begin
      cfg_r <= i_cfg_sw;
    end
  end

  assign o_cfg_drv = (state_r == BFM_CAPTURE) ? CFG_RST : cfg_r;
  assign o_cfg_oe_n = (state_r != BFM_HOLD);
  assign o_dsp_rst_n = (state_r == BFM_RUN);

  cfg_catch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r == BFM_CAPTURE) |=> (o_cfg_drv == $past(i_cfg_sw)) && !o_cfg_oe_n)
    else $error("switch levels not caught at reset");
  cfg_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_dsp_rst_n && !o_cfg_oe_n |=> $stable(o_cfg_drv))
    else $error("config drive changed during dsp reset");
endmodule : bfm_cfg_latch

// ==== verif/bfm_flash_model.sv ====
`timescale 1ns/1ps
module bfm_flash_model
(
  input wire logic i_mclk,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic i_ce_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_rb
);
  logic [7:0] mem_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic we_d_r = 1'b1;
  logic [1:0] busy_r = 2'h0;
  // released bus shows the inverse of the last byte so a stale value never matches
  assign o_data = (!i_ce_n && !i_re_n) ? mem_r : ~last_r;
  assign o_rb = (busy_r == 2'h0);
  always @(posedge i_mclk)
  begin
    we_d_r <= i_we_n;
    if (busy_r != 2'h0)
      busy_r <= busy_r - 2'h1;
    if (i_we_n && !we_d_r && !i_ce_n && !i_cle && !i_ale)
    begin
      // a protected flash drops the byte, yet still goes busy
      if (i_wp_n)
        mem_r <= i_data;
      busy_r <= 2'h3;
    end
    if (!i_ce_n && !i_re_n)
      last_r <= mem_r;
  end
endmodule : bfm_flash_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module testbench;
  import bfm_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, boot = 1'b0, strobe = 1'b0, re_n = 1'b1, ce_n = 1'b1, mode = 1'b0, irq = 1'b0;
  logic [15:0] cfg_sw = 16'ha5c3;
  logic [7:0] gp_drv = 8'h00;
  logic [1:0] cmd = 2'h0, user_sw = 2'h0;
  wire [15:0] cfg_drv;
  wire [7:0] gp_out, fl_out, fl_model, gp_wire, fl_wire;
  wire cfg_oe_n, dsp_rst_n, gp_oe_n, ready, irq_pin, fl_oe_n, cle, ale, we_n, fre_n, fce_n, wp_n, rb;
  wire [1:0] led;
  int errors = 0;
  int cmp_count = 0;
  assign gp_wire = !gp_oe_n ? gp_out : gp_drv;
  assign fl_wire = !fl_oe_n ? fl_out : fl_model;
  bfm_top u_bfm_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_cfg_sw(cfg_sw), .o_cfg_drv(cfg_drv),
    .o_cfg_oe_n(cfg_oe_n), .o_dsp_rst_n(dsp_rst_n), .i_boot_done(boot), .i_gp_data(gp_wire),
    .o_gp_data(gp_out), .o_gp_data_oe_n(gp_oe_n), .i_bus_command_pins(cmd), .i_gp_strobe(strobe),
    .o_cycle_ready_pin(ready), .i_gp_re_n(re_n), .i_gp_ce_n(ce_n), .i_mode_select(mode),
    .o_bridge_irq_pin(irq_pin), .i_bridge_irq(irq), .i_flash_data(fl_wire), .o_flash_data(fl_out),
    .o_flash_data_oe_n(fl_oe_n), .o_flash_cle(cle), .o_flash_ale(ale), .o_flash_we_n(we_n),
    .o_flash_re_n(fre_n), .o_flash_ce_n(fce_n), .o_flash_wp_n(wp_n), .i_flash_rb(rb),
    .o_user_led(led), .i_user_sw(user_sw));
  bfm_flash_model u_bfm_flash_model (.i_mclk(i_mclk), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
    .i_re_n(fre_n), .i_ce_n(fce_n), .i_wp_n(wp_n), .i_data(fl_wire), .o_data(fl_model), .o_rb(rb));
  initial
  begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  // one strobe period; request held until ready is seen high at an edge
  task automatic cyc(input logic [1:0] c, input logic [7:0] d, output logic [7:0] q, output logic lo);
    int n;
    lo = 1'b0;
    @(posedge i_mclk);
    cmd <= c;
    gp_drv <= d;
    strobe <= 1'b1;
    @(posedge i_mclk);
    // ready is read at the falling edge, where it already shows what the next rising edge samples
    for (n = 0; n < 20; n++)
    begin
      @(negedge i_mclk);
      if (ready === 1'b1)
        break;
      lo = 1'b1;
    end
    `CHK(ready, 1'b1)
    q = gp_wire;
    @(posedge i_mclk);
    strobe <= 1'b0;
    @(posedge i_mclk);
  endtask : cyc
  task automatic acc(input logic [1:0] c, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic lo);
    logic [7:0] x;
    cyc(CMD_ADDR, a, x, lo);
    cyc(c, d, q, lo);
  endtask : acc
  task automatic t_boot;
    logic [7:0] q;
    logic lo;
    @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK(cfg_drv, 16'ha5c3)
    `CHK({cfg_oe_n, dsp_rst_n}, 2'b00)
    @(posedge i_mclk);
    cfg_sw <= 16'h0000;
    mode <= 1'b1;
    acc(CMD_READ, REG_CFG_HI, 8'h00, q, lo);
    `CHK(q, 8'ha5)
    acc(CMD_READ, REG_CFG_LO, 8'h00, q, lo);
    `CHK(q, 8'hc3)
    `CHK(cfg_drv, 16'ha5c3)
    repeat (210) @(negedge i_mclk);
    `CHK({cfg_oe_n, dsp_rst_n}, 2'b11)
    acc(CMD_READ, REG_STATUS, 8'h00, q, lo);
    `CHK(q[STAT_PASS_BIT], 1'b0)
    $display("t_boot done");
  endtask : t_boot
  task automatic t_regs;
    logic [7:0] q;
    logic lo;
    mode <= 1'b0;
    user_sw <= 2'b10;
    acc(CMD_WRITE, REG_USER, 8'h03, q, lo);
    `CHK(led, 2'b11)
    cyc(CMD_IDLE, 8'h00, q, lo);
    acc(CMD_READ, REG_USER, 8'h00, q, lo);
    `CHK(q, 8'h23)
    `CHK(lo, 1'b1)
    acc(CMD_READ, 8'h05, 8'h00, q, lo);
    `CHK(q, 8'h00)
    `CHK(wp_n, 1'b0)
    acc(CMD_WRITE, REG_FLASH_CTL_H, 8'h10, q, lo);
    `CHK(wp_n, 1'b1)
    `CHK(lo, 1'b1)
    acc(CMD_READ, REG_FLASH_CTL_H, 8'h00, q, lo);
    `CHK(q, 8'h10)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_pass;
    int v;
    @(posedge i_mclk);
    boot <= 1'b1;
    mode <= 1'b1;
    cmd <= CMD_WRITE;
    gp_drv <= 8'h00;
    repeat (3) @(posedge i_mclk);
    strobe <= 1'b1;
    @(posedge i_mclk);
    strobe <= 1'b0;
    repeat (4) @(posedge i_mclk);
    `CHK({led, wp_n}, 3'h7)
    cmd <= 2'b01;
    gp_drv <= 8'h5a;
    ce_n <= 1'b0;
    @(negedge i_mclk);
    `CHK({cle, ale, we_n, fre_n, fce_n, fl_out}, {5'b10010, 8'h5a})
    `CHK(wp_n, 1'b1)
    for (v = 0; v < 2; v++)
    begin
      @(posedge i_mclk);
      irq <= (v == 0);
      @(negedge i_mclk);
      `CHK(irq_pin, (v == 0))
    end
    @(posedge i_mclk);
    cmd <= 2'b00;
    @(posedge i_mclk);
    strobe <= 1'b1;
    @(negedge i_mclk);
    @(negedge i_mclk);
    `CHK(ready, 1'b0)
    repeat (4) @(posedge i_mclk);
    re_n <= 1'b0;
    @(negedge i_mclk);
    `CHK({gp_oe_n, gp_wire, ready}, {1'b0, 8'h5a, 1'b1})
    $display("t_pass done");
  endtask : t_pass
  task automatic t_back;
    logic [7:0] q;
    logic lo;
    @(posedge i_mclk);
    mode <= 1'b0;
    strobe <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK({cle, ale, we_n, fre_n, fce_n}, 5'b00111)
    acc(CMD_READ, REG_STATUS, 8'h00, q, lo);
    `CHK(q[1:0], 2'b01)
    `CHK(wp_n, 1'b1)
    $display("t_back done");
  endtask : t_back
  task automatic conclude;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial
  begin
    #20000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_boot();
    t_regs();
    t_pass();
    t_back();
    conclude();
  end
endmodule : testbench
